// File: logic/ldc_defines.svh
// offsets, field positions, reset values and timing counts of the led control block
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

// target addresses, seven bits
`define LDC_ADDR_STD      7'h36
`define LDC_ADDR_ALT      7'h38

// internal register addresses
`define LDC_OFS_GEN       8'h10
`define LDC_OFS_MAIN      8'ha0
`define LDC_OFS_AUX       8'hb0
`define LDC_OFS_IND       8'hc0

// power-on values
`define LDC_RST_GEN       8'h20
`define LDC_RST_MAIN      8'he0
`define LDC_RST_AUX       8'he0
`define LDC_RST_IND       8'hfc

// general control field positions
`define LDC_BIT_MAIN_ON   0
`define LDC_BIT_AUX_ON    1
`define LDC_BIT_IND_ON    2
`define LDC_BIT_FIFTH_ON  3
`define LDC_BIT_THIRD_ON  4
`define LDC_GEN_FIXED     3'h1
`define LDC_LEVEL_FILL    3'h7
`define LDC_IND_FILL      6'h3f

// timing
`define LDC_CLK_PERIOD_NS 50
`define LDC_PWM_PERIOD_NS 50000
`define LDC_PWM_CYCLES    (`LDC_PWM_PERIOD_NS / `LDC_CLK_PERIOD_NS)
`define LDC_PWM_SLOTS     16

`endif

// File: logic/ldc_pkg.sv
// types of the led control block
package ldc_pkg;

   // serial target states, gray steps along idle-rx-ack-tx-mack
   typedef enum logic [2:0]
   {
      ldc_st_idle = 3'b000,
      ldc_st_rx   = 3'b001,
      ldc_st_ack  = 3'b011,
      ldc_st_tx   = 3'b010,
      ldc_st_mack = 3'b110
   } ldc_state_t;

   // analog current step: 20, 40, 70, 100 percent
   typedef enum logic [1:0]
   {
      ldc_cur_20  = 2'h0,
      ldc_cur_40  = 2'h1,
      ldc_cur_70  = 2'h2,
      ldc_cur_100 = 2'h3
   } ldc_current_t;

endpackage

// File: logic/ldc_level_map.sv
// maps a five-bit brightness code to analog current step and pwm duty
`timescale 1ns/10ps
module ldc_level_map
(
   input  wire logic [4:0]          code,
   output ldc_pkg::ldc_current_t    current,
   output logic      [4:0]          duty
);

   // duty is in sixteenths, 1..16
   always_comb
   begin
      if (code <= 5'h0f)
      begin
         current = ldc_pkg::ldc_cur_20;
         duty    = code + 5'h01;
      end
      else if (code <= 5'h16)
      begin
         current = ldc_pkg::ldc_cur_40;
         duty    = code - 5'h06;
      end
      else if (code <= 5'h1c)
      begin
         current = ldc_pkg::ldc_cur_70;
         duty    = code - 5'h0c;
      end
      else
      begin
         current = ldc_pkg::ldc_cur_100;
         duty    = (code == 5'h1d) ? 5'h0d :
                   (code == 5'h1e) ? 5'h0f : 5'h10;
      end
   end

endmodule

// File: logic/ldc_ctrl.sv
// two-wire target, control registers, pwm dimming and pump gain choice
//
// Overview of operation
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - bus busy from start until stop
// - repeated start restarts address reception
// - data changes only while scl low
// - bytes are eight bits, msb first
// - target pulls sda low on ninth pulse
// - first byte is address plus direction bit
// - answer only to selected seven-bit address
// - second byte selects register, third stores
// - general control holds five enables, bit5 one
// - bits 0-2 enable main, aux, indicator
// - bit4 third aux sink, bit3 fifth sense
// - brightness registers at a0, b0, c0
// - main and aux take five-bit codes
// - indicator takes two-bit code
// - low codes map to 20 percent
// - upper codes map to 40, 70, 100 percent
// - pwm dimming runs at 20 khz
// - indicator code picks 20/40/70/100 percent
// - low sink pin switches pump to 3/2
// - only enabled main/aux pins steer gain
// - reset pin low restores defaults, disables drive
`timescale 1ns/10ps
`include "ldc_defines.svh"
module ldc_ctrl
(
   input  wire logic                  ref_clk,
   input  wire logic                  sys_rst,
   input  wire logic                  scl,
   input  wire logic                  sda_in,
   output logic                       sda_out,
   output logic                       sda_oe,
   input  wire logic                  reset_n,
   input  wire logic                  alt_addr_sel,
   input  wire logic [4:0]            main_sink_low,
   input  wire logic [2:0]            aux_sink_low,
   output logic                       bus_busy,
   output logic                       main_group_drive,
   output ldc_pkg::ldc_current_t      main_group_current,
   output logic                       main_fifth_sense_on,
   output logic                       aux_group_drive,
   output logic                       aux_third_sink_drive,
   output ldc_pkg::ldc_current_t      aux_group_current,
   output logic                       indicator_drive,
   output ldc_pkg::ldc_current_t      indicator_current,
   output logic                       pump_gain_3_2
);

   localparam logic [11:0] SYNC_RST = 12'h003;
   localparam logic [9:0]  PWM_LAST = 10'(`LDC_PWM_CYCLES - 1);

   ldc_pkg::ldc_state_t    state_q;
   ldc_pkg::ldc_state_t    state_d;
   ldc_pkg::ldc_current_t  main_cur_w;
   ldc_pkg::ldc_current_t  aux_cur_w;
   logic [11:0]            meta_q;
   logic [11:0]            sync_q;
   logic                   scl_p_q;
   logic                   sda_p_q;
   logic                   busy_q;
   logic [3:0]             bit_cnt_q;
   logic [1:0]             byte_idx_q;
   logic                   rw_q;
   logic [7:0]             shift_q;
   logic [7:0]             ptr_q;
   logic [7:0]             gen_q;
   logic [7:0]             main_q;
   logic [7:0]             aux_q;
   logic [7:0]             ind_q;
   logic                   alt_q;
   logic [1:0]             strap_cnt_q;
   logic [9:0]             pwm_cnt_q;
   logic                   gain_q;
   logic                   main_drv_q;
   logic                   aux_drv_q;
   logic                   aux3_drv_q;
   logic                   ind_drv_q;
   logic                   fifth_q;
   ldc_pkg::ldc_current_t  main_cur_q;
   ldc_pkg::ldc_current_t  aux_cur_q;
   ldc_pkg::ldc_current_t  ind_cur_q;
   logic [4:0]             main_duty_w;
   logic [4:0]             aux_duty_w;

   // register write formatting is used four times, pwm compare twice
   function automatic logic pwm_on(input logic [9:0] cnt,
                                   input logic [4:0] duty);
      logic [13:0] pos;
      logic [13:0] lim;
      pos = {cnt, 4'h0};
      lim = 14'(duty) * 14'(`LDC_PWM_CYCLES);
      return pos < lim;
   endfunction

   function automatic logic [7:0] write_value(input logic [7:0] ptr,
                                              input logic [7:0] d,
                                              input logic [7:0] old);
      unique case (ptr)
         `LDC_OFS_GEN:  return {`LDC_GEN_FIXED, d[4:0]};
         `LDC_OFS_MAIN: return {`LDC_LEVEL_FILL, d[4:0]};
         `LDC_OFS_AUX:  return {`LDC_LEVEL_FILL, d[4:0]};
         `LDC_OFS_IND:  return {`LDC_IND_FILL, d[1:0]};
         default:       return old;
      endcase
   endfunction

   // pin synchroniser: every outside level passes two flops
   wire [11:0] raw_w = {aux_sink_low, main_sink_low, alt_addr_sel,
                        reset_n, sda_in, scl};

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
      end
      else
      begin
         meta_q <= raw_w;
         sync_q <= meta_q;
      end
   end

   wire       scl_s     = sync_q[0];
   wire       sda_s     = sync_q[1];
   wire       hw_rst_n  = sync_q[2];
   wire       alt_s     = sync_q[3];
   wire [4:0] main_low  = sync_q[8:4];
   wire [2:0] aux_low   = sync_q[11:9];

   wire scl_rise  = scl_s & ~scl_p_q;
   wire scl_fall  = ~scl_s & scl_p_q;
   wire start_w   = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_w    = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire in_rx     = state_q == ldc_pkg::ldc_st_rx;
   wire in_ack    = state_q == ldc_pkg::ldc_st_ack;
   wire in_tx     = state_q == ldc_pkg::ldc_st_tx;
   wire in_mack   = state_q == ldc_pkg::ldc_st_mack;
   wire byte_done = in_rx & scl_fall & (bit_cnt_q == 4'h8);
   wire [6:0] my_addr = alt_q ? `LDC_ADDR_ALT : `LDC_ADDR_STD;
   wire addr_hit  = shift_q[7:1] == my_addr;
   wire ptr_load  = byte_done & (byte_idx_q == 2'h1);
   wire wr_pulse  = byte_done & (byte_idx_q == 2'h2);
   wire ack_exit  = in_ack & scl_fall;
   wire tx_load   = (ack_exit & rw_q) | (in_mack & scl_fall & ~sda_p_q);

   // unmapped addresses read as zero
   wire [7:0] read_w = (ptr_q == `LDC_OFS_GEN)  ? gen_q  :
                       (ptr_q == `LDC_OFS_MAIN) ? main_q :
                       (ptr_q == `LDC_OFS_AUX)  ? aux_q  :
                       (ptr_q == `LDC_OFS_IND)  ? ind_q  : 8'h00;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ldc_pkg::ldc_st_idle: state_d = state_q;
         ldc_pkg::ldc_st_rx:
            if (byte_done)
               state_d = (byte_idx_q == 2'h0 && !addr_hit) ?
                         ldc_pkg::ldc_st_idle : ldc_pkg::ldc_st_ack;
         ldc_pkg::ldc_st_ack:
            if (scl_fall)
               state_d = rw_q ? ldc_pkg::ldc_st_tx : ldc_pkg::ldc_st_rx;
         ldc_pkg::ldc_st_tx:
            if (scl_fall && bit_cnt_q == 4'h7)
               state_d = ldc_pkg::ldc_st_mack;
         ldc_pkg::ldc_st_mack:
            if (scl_rise && sda_s)
               state_d = ldc_pkg::ldc_st_idle;
            else if (scl_fall)
               state_d = ldc_pkg::ldc_st_tx;
         default: state_d = ldc_pkg::ldc_st_idle;
      endcase
      if (stop_w)
         state_d = ldc_pkg::ldc_st_idle;
      if (start_w)
         state_d = ldc_pkg::ldc_st_rx;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         state_q <= ldc_pkg::ldc_st_idle;
         busy_q  <= 1'b0;
      end
      else
      begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         state_q <= state_d;
         if (start_w)
            busy_q <= 1'b1;
         else if (stop_w)
            busy_q <= 1'b0;
      end
   end

   // bit count, byte position and shifter
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bit_cnt_q  <= 4'h0;
         byte_idx_q <= 2'h0;
         rw_q       <= 1'b0;
         shift_q    <= 8'h00;
      end
      else if (start_w)
      begin
         bit_cnt_q  <= 4'h0;
         byte_idx_q <= 2'h0;
         rw_q       <= 1'b0;
      end
      else
      begin
         if (in_rx && scl_rise)
         begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         if (byte_done && byte_idx_q == 2'h0)
            rw_q <= shift_q[0];
         if (ack_exit)
         begin
            bit_cnt_q <= 4'h0;
            if (byte_idx_q != 2'h2)
               byte_idx_q <= byte_idx_q + 2'h1;
         end
         if (tx_load)
         begin
            shift_q   <= read_w;
            bit_cnt_q <= 4'h0;
         end
         else if (in_tx && scl_fall)
         begin
            shift_q   <= {shift_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
      end
   end

   // open drain: only ever pulls low, changes follow scl falls only
   assign sda_out  = 1'b0;
   assign sda_oe   = in_ack | (in_tx & ~shift_q[7]);
   assign bus_busy = busy_q;

   // strap follows the pin until the synchroniser has filled, then freezes;
   // the first edges after release only see the synchroniser reset value
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         alt_q       <= 1'b0;
         strap_cnt_q <= 2'h0;
      end
      else if (strap_cnt_q != 2'h3)
      begin
         alt_q       <= alt_s;
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   // control registers; the reset pin restores them synchronously
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ptr_q  <= 8'h00;
         gen_q  <= `LDC_RST_GEN;
         main_q <= `LDC_RST_MAIN;
         aux_q  <= `LDC_RST_AUX;
         ind_q  <= `LDC_RST_IND;
      end
      else if (!hw_rst_n)
      begin
         ptr_q  <= 8'h00;
         gen_q  <= `LDC_RST_GEN;
         main_q <= `LDC_RST_MAIN;
         aux_q  <= `LDC_RST_AUX;
         ind_q  <= `LDC_RST_IND;
      end
      else
      begin
         if (ptr_load)
            ptr_q <= shift_q;
         if (wr_pulse && ptr_q == `LDC_OFS_GEN)
            gen_q <= write_value(ptr_q, shift_q, gen_q);
         if (wr_pulse && ptr_q == `LDC_OFS_MAIN)
            main_q <= write_value(ptr_q, shift_q, main_q);
         if (wr_pulse && ptr_q == `LDC_OFS_AUX)
            aux_q <= write_value(ptr_q, shift_q, aux_q);
         if (wr_pulse && ptr_q == `LDC_OFS_IND)
            ind_q <= write_value(ptr_q, shift_q, ind_q);
      end
   end

   wire main_group_on       = gen_q[`LDC_BIT_MAIN_ON];
   wire aux_group_on        = gen_q[`LDC_BIT_AUX_ON];
   wire indicator_on        = gen_q[`LDC_BIT_IND_ON];
   wire main_fifth_sense_en = gen_q[`LDC_BIT_FIFTH_ON];
   wire aux_third_sink_on   = gen_q[`LDC_BIT_THIRD_ON];

   ldc_level_map u_main_map
   (
      .code    (main_q[4:0]),
      .current (main_cur_w),
      .duty    (main_duty_w)
   );

   ldc_level_map u_aux_map
   (
      .code    (aux_q[4:0]),
      .current (aux_cur_w),
      .duty    (aux_duty_w)
   );

   // 20 khz timebase shared by both dimmed groups
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         pwm_cnt_q <= 10'h000;
      else
         pwm_cnt_q <= (pwm_cnt_q == PWM_LAST) ? 10'h000
                                               : pwm_cnt_q + 10'h001;
   end

   wire main_pwm_w = pwm_on(pwm_cnt_q, main_duty_w);
   wire aux_pwm_w  = pwm_on(pwm_cnt_q, aux_duty_w);

   // only enabled main and aux pins are watched; indicator never is
   wire [4:0] main_mon_w = main_group_on ?
      (main_low & {main_fifth_sense_en, 4'hf}) : 5'h00;
   wire [2:0] aux_mon_w  = aux_group_on ?
      (aux_low & {aux_third_sink_on, 2'h3}) : 3'h0;
   wire any_low_w  = |{main_mon_w, aux_mon_w};
   wire any_mon_w  = main_group_on | aux_group_on;

   // gain stays raised until monitoring stops or the reset pin goes low; avoids toggling at threshold
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         gain_q <= 1'b0;
      else if (!hw_rst_n || !any_mon_w)
         gain_q <= 1'b0;
      else if (any_low_w)
         gain_q <= 1'b1;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         main_drv_q <= 1'b0;
         aux_drv_q  <= 1'b0;
         aux3_drv_q <= 1'b0;
         ind_drv_q  <= 1'b0;
         fifth_q    <= 1'b0;
         main_cur_q <= ldc_pkg::ldc_cur_20;
         aux_cur_q  <= ldc_pkg::ldc_cur_20;
         ind_cur_q  <= ldc_pkg::ldc_cur_20;
      end
      else
      begin
         main_drv_q <= hw_rst_n & main_group_on & main_pwm_w;
         aux_drv_q  <= hw_rst_n & aux_group_on & aux_pwm_w;
         aux3_drv_q <= hw_rst_n & aux_group_on & aux_third_sink_on
                       & aux_pwm_w;
         ind_drv_q  <= hw_rst_n & indicator_on;
         fifth_q    <= hw_rst_n & main_fifth_sense_en;
         main_cur_q <= main_cur_w;
         aux_cur_q  <= aux_cur_w;
         ind_cur_q  <= ldc_pkg::ldc_current_t'(ind_q[1:0]);
      end
   end

   assign main_group_drive     = main_drv_q;
   assign main_group_current   = main_cur_q;
   assign main_fifth_sense_on  = fifth_q;
   assign aux_group_drive      = aux_drv_q;
   assign aux_third_sink_drive = aux3_drv_q;
   assign aux_group_current    = aux_cur_q;
   assign indicator_drive      = ind_drv_q;
   assign indicator_current    = ind_cur_q;
   assign pump_gain_3_2        = gain_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   start_enter_a: assert property (start_w |=> in_rx && bit_cnt_q == 4'h0 && byte_idx_q == 2'h0)
      else $error("start did not restart address reception");
   stop_free_a: assert property (stop_w && !start_w |=> !busy_q && state_q == ldc_pkg::ldc_st_idle)
      else $error("stop did not free the bus");
   busy_hold_a: assert property (busy_q && !stop_w |=> busy_q)
      else $error("bus freed without stop");
   ack_pull_a: assert property (byte_done && byte_idx_q != 2'h0 && !start_w && !stop_w |=> sda_oe [*1] ##0 in_ack)
      else $error("received byte not acknowledged");
   addr_miss_a: assert property (byte_done && byte_idx_q == 2'h0 && !addr_hit && !start_w |=> !sda_oe && state_q == ldc_pkg::ldc_st_idle)
      else $error("foreign address acknowledged");
   gen_write_a: assert property (wr_pulse && ptr_q == `LDC_OFS_GEN && hw_rst_n |=> gen_q == {3'h1, $past(shift_q[4:0])})
      else $error("general control write wrong");
   gen_fixed_a: assert property (gen_q[7:5] == 3'h1 && ind_q[7:2] == 6'h3f)
      else $error("fixed bits disturbed");
   tx_stable_a: assert property (in_tx && scl_s && $stable(state_q) |=> $stable(sda_oe) || !scl_s)
      else $error("sda moved while scl high");
   hw_reset_a: assert property (!hw_rst_n |=> gen_q == `LDC_RST_GEN && main_q == `LDC_RST_MAIN ##1 !main_group_drive && !indicator_drive)
      else $error("reset pin did not restore defaults");
   gain_cause_a: assert property ($rose(gain_q) |-> $past(any_low_w) && $past(any_mon_w))
      else $error("gain raised without monitored low pin");
   pwm_wrap_a: assert property (pwm_cnt_q == PWM_LAST |=> pwm_cnt_q == 10'h000)
      else $error("pwm period wrong");

endmodule

// File: tb/ldc_bus_master.sv
// behavioural two-wire bus master for the led control block
`timescale 1ns/10ps
module ldc_bus_master
(
   input  wire logic ref_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // every pin change lands 1 ns after a clock edge, never on it
   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // b=1 start (sda falls, scl high), b=0 stop (sda rises, scl high)
   task automatic cond(input logic b);
      sda_low = !b;
      tk(2);
      scl = 1'b1;
      tk(4);
      sda_low = b;
      tk(4);
      if (b)
      begin
         scl = 1'b0;
         tk(2);
      end
   endtask

   // one 400 ns pulse; sda only moves while scl is low
   task automatic bit_cyc(input logic low, output logic seen);
      sda_low = low;
      tk(2);
      scl = 1'b1;
      tk(2);
      seen = sda;
      tk(2);
      scl = 1'b0;
      tk(2);
   endtask

   task automatic wb(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_cyc(!b[i], s);
      bit_cyc(1'b0, s);
      ack = !s;
   endtask

   // last=1 leaves sda released on the ninth pulse to end the read
   task automatic rb(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_cyc(1'b0, s);
         b[i] = s;
      end
      bit_cyc(!last, s);
   endtask
endmodule

// File: tb/test_led_dimming_i2c_control.sv
// self-checking bench of the led control block
`timescale 1ns/10ps
module test_led_dimming_i2c_control;
   logic                  ref_clk;
   logic                  sys_rst;
   logic                  reset_n;
   logic                  alt_addr_sel;
   logic [4:0]            main_sink_low;
   logic [2:0]            aux_sink_low;
   logic                  scl;
   logic                  sda_low;
   logic                  sda_out;
   logic                  sda_oe;
   logic                  bus_busy;
   logic                  m_drv;
   logic                  a_drv;
   logic                  t_drv;
   logic                  i_drv;
   logic                  fifth;
   logic                  gain;
   ldc_pkg::ldc_current_t m_cur;
   ldc_pkg::ldc_current_t a_cur;
   ldc_pkg::ldc_current_t i_cur;
   logic [6:0]            addr;
   int                    n_fail;
   int                    n_checks;
   // pulled-up wire: low when either party pulls it
   wire sda = !(sda_low || (sda_oe && !sda_out));

   ldc_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .reset_n(reset_n), .alt_addr_sel(alt_addr_sel),
      .main_sink_low(main_sink_low), .aux_sink_low(aux_sink_low),
      .bus_busy(bus_busy), .main_group_drive(m_drv),
      .main_group_current(m_cur), .main_fifth_sense_on(fifth),
      .aux_group_drive(a_drv), .aux_third_sink_drive(t_drv),
      .aux_group_current(a_cur), .indicator_drive(i_drv),
      .indicator_current(i_cur), .pump_gain_3_2(gain));

   ldc_bus_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl),
      .sda_low(sda_low));

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic a;
      m.cond(1'b1);
      m.wb({addr, 1'b0}, a);
      chk("addr ack", 16'h1, {15'h0, a});
      m.wb(ofs, a);
      m.wb(d, a);
      chk("data ack", 16'h1, {15'h0, a});
      m.cond(1'b0);
   endtask

   task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
      logic a;
      m.cond(1'b1);
      m.wb({addr, 1'b0}, a);
      m.wb(ofs, a);
      m.cond(1'b1);
      m.wb({addr, 1'b1}, a);
      chk("read ack", 16'h1, {15'h0, a});
      m.rb(1'b1, d);
      m.cond(1'b0);
   endtask

   // unused bits read back at their power-on level
   function automatic logic [7:0] rdv(input logic [7:0] o,
                                      input logic [7:0] d);
      case (o)
         8'h10: rdv = {3'h1, d[4:0]};
         8'ha0, 8'hb0: rdv = {3'h7, d[4:0]};
         8'hc0: rdv = {6'h3f, d[1:0]};
         default: rdv = 8'h00;
      endcase
   endfunction

   function automatic logic [15:0] cur(input logic [4:0] c);
      cur = (c < 5'h10) ? 16'h0 : (c < 5'h17) ? 16'h1
          : (c < 5'h1d) ? 16'h2 : 16'h3;
   endfunction

   // gate-on cycles in one 1000-cycle pwm period
   function automatic logic [15:0] on_cnt(input logic [4:0] c);
      int d;
      d = (c < 5'h10) ? c + 1 : (c < 5'h17) ? c - 6
        : (c < 5'h1d) ? c - 12 : (c == 5'h1d) ? 13 : (c == 5'h1e) ? 15 : 16;
      on_cnt = 16'((d * 1000 + 15) / 16);
   endfunction

   // pump gain after the pins settle; held until both groups are off
   function automatic logic gexp(input logic p, input logic [7:0] g,
                                 input logic [4:0] mp, input logic [2:0] ap);
      gexp = (g[0] | g[1]) & (p | (g[0] & (|(mp & {g[3], 4'hf})))
             | (g[1] & (|(ap & {g[4], 2'h3}))));
   endfunction

   task automatic meas(output int nm, output int na, output int nt);
      nm = 0;
      na = 0;
      nt = 0;
      repeat (1000)
      begin
         m.tk(1);
         nm += (m_drv === 1'b1);
         na += (a_drv === 1'b1);
         nt += (t_drv === 1'b1);
      end
   endtask

   initial
   begin
      #4000000;
      n_fail++;
      end_sim();
   end

   initial
   begin
      logic [7:0] ofs[5] = '{8'h10, 8'ha0, 8'hb0, 8'hc0, 8'h55};
      logic [7:0] rv[5] = '{8'h20, 8'he0, 8'he0, 8'hfc, 8'h00};
      logic [7:0] gg[10] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h02,
                             8'h02, 8'h00, 8'h09, 8'h00, 8'h12};
      logic [4:0] ml[10] = '{5'h10, 5'h00, 5'h01, 5'h00, 5'h02,
                             5'h00, 5'h00, 5'h10, 5'h00, 5'h00};
      logic [2:0] al[10] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h0,
                             3'h1, 3'h0, 3'h0, 3'h0, 3'h4};
      logic       ge;
      logic [7:0] q;
      logic [7:0] r;
      logic       a;
      int         nm;
      int         na;
      int         nt;
      n_fail = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      reset_n = 1'b1;
      alt_addr_sel = 1'b0;
      main_sink_low = 5'h00;
      aux_sink_low = 3'h0;
      addr = 7'h36;
      void'($urandom(21829));
      repeat (2) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      m.tk(6);
      for (int k = 0; k < 5; k++)
      begin
         rd(ofs[k], q);
         chk("power-on value", {8'h0, rv[k]}, {8'h0, q});
      end
      for (int k = 0; k < 5; k++)
      begin
         r = 8'($urandom);
         wr(ofs[k], r);
         rd(ofs[k], q);
         chk("readback", {8'h0, rdv(ofs[k], r)}, {8'h0, q});
      end
      $display("test registers done");
      m.cond(1'b1);
      m.wb({addr, 1'b0}, a);
      m.cond(1'b1);
      chk("busy", 16'h1, {15'h0, bus_busy});
      m.wb({addr, 1'b0}, a);
      m.wb(8'hc0, a);
      m.wb(8'h02, a);
      m.cond(1'b0);
      chk("free", 16'h0, {15'h0, bus_busy});
      rd(8'hc0, q);
      chk("restart write", 16'hfe, {8'h0, q});
      $display("test repeated start done");
      wr(8'h10, 8'h0f);
      for (int c = 0; c < 32; c++)
      begin
         r = 8'($urandom);
         wr(8'ha0, {r[7:5], 5'(c)});
         wr(8'hb0, {r[2:0], 5'(31 - c)});
         meas(nm, na, nt);
         chk("main current", cur(5'(c)), {14'h0, m_cur});
         chk("aux current", cur(5'(31 - c)), {14'h0, a_cur});
         chk("main on", on_cnt(5'(c)), 16'(nm));
         chk("aux on", on_cnt(5'(31 - c)), 16'(na));
         chk("third off", 16'h0, 16'(nt));
      end
      wr(8'h10, 8'h1a);
      wr(8'hb0, 8'(r[4:0]));
      meas(nm, na, nt);
      chk("main gated", 16'h0, 16'(nm));
      chk("third on", on_cnt(r[4:0]), 16'(nt));
      chk("fifth sense", 16'h1, {15'h0, fifth});
      for (int c = 0; c < 4; c++)
      begin
         wr(8'hc0, {6'(c * 9), 2'(c)});
         chk("ind current", 16'(c), {14'h0, i_cur});
         chk("ind off", 16'h0, {15'h0, i_drv});
      end
      $display("test dimming done");
      ge = 1'b0;
      for (int k = 0; k < 20; k++)
      begin
         wr(8'h10, gg[k % 10]);
         ge = gexp(ge, gg[k % 10], main_sink_low, aux_sink_low);
         main_sink_low = (k < 10) ? ml[k % 10] : 5'($urandom);
         aux_sink_low = (k < 10) ? al[k % 10] : 3'($urandom);
         ge = gexp(ge, gg[k % 10], main_sink_low, aux_sink_low);
         m.tk(20);
         chk("pump gain", {15'h0, ge}, {15'h0, gain});
      end
      $display("test pump gain done");
      wr(8'ha0, 8'h1f);
      wr(8'h10, 8'h07);
      chk("ind on", 16'h1, {15'h0, i_drv});
      reset_n = 1'b0;
      m.tk(6);
      chk("drive in reset", 16'h0, {12'h0, m_drv, a_drv, i_drv, gain});
      reset_n = 1'b1;
      m.tk(4);
      rd(8'h10, q);
      chk("gen after pin reset", 16'h20, {8'h0, q});
      rd(8'ha0, q);
      chk("main after pin reset", 16'he0, {8'h0, q});
      $display("test reset pin done");
      alt_addr_sel = ~alt_addr_sel;
      m.tk(4);
      sys_rst = 1'b1;
      m.tk(2);
      sys_rst = 1'b0;
      m.tk(6);
      m.cond(1'b1);
      m.wb({7'h36, 1'b0}, a);
      m.cond(1'b0);
      chk("foreign addr", 16'h0, {15'h0, a});
      addr = 7'h38;
      wr(8'hc0, 8'h01);
      rd(8'hc0, q);
      chk("alt addr", 16'hfd, {8'h0, q});
      $display("test alternate address done");
      end_sim();
   end
endmodule
